// *** tcp_timer.sv ***
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ns
// Timer/counter top with AXI4-Lite register slave
module tcp_timer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic external_count_input,
  input wire logic pin_direction_control,
  output logic count_pin_input_mode,
  output logic prescaler_to_watchdog,
  output logic watchdog_clear_instruction
);
  tcp_pkg::tcp_cfg_type cfg;
  logic [7:0] option_q;
  logic [7:0] option_d;
  logic [7:0] count_q;
  logic [7:0] count_d;
  logic [1:0] inhibit_q;
  logic [1:0] inhibit_d;
  logic pin_q;
  logic pin_d;
  logic sync_q;
  logic sync_d;
  logic sync_prev_q;
  logic sync_prev_d;
  logic dir_q;
  logic dir_d;
  logic assign_q;
  logic assign_d;
  logic wclr_q;
  logic wclr_d;
  logic aw_held_q;
  logic aw_held_d;
  logic w_held_q;
  logic w_held_d;
  logic [31:0] awaddr_q;
  logic [31:0] awaddr_d;
  logic [31:0] wdata_q;
  logic [31:0] wdata_d;
  logic [3:0] wstrb_q;
  logic [3:0] wstrb_d;
  logic bvalid_q;
  logic bvalid_d;
  logic [1:0] bresp_q;
  logic [1:0] bresp_d;
  logic rvalid_q;
  logic rvalid_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [1:0] rresp_q;
  logic [1:0] rresp_d;
  logic awready_q;
  logic awready_d;
  logic wready_q;
  logic wready_d;
  logic arready_q;
  logic arready_d;
  logic cycle_end;
  logic sample_en;
  logic pin_edge;
  logic pre_tap;
  logic pre_clear;
  logic pre_out;
  logic inc_src;
  logic wr_go;
  logic wr_count;
  logic wr_option;
  logic wr_cmd;

  // Option register fields
  assign cfg.src_ext = option_q[tcp_pkg::TCP_SRC_BIT];
  assign cfg.edge_fall = option_q[tcp_pkg::TCP_EDGE_BIT];
  assign cfg.to_wdt = option_q[tcp_pkg::TCP_ASSIGN_BIT];
  assign cfg.ratio = option_q[tcp_pkg::TCP_RATIO_MSB:0];

  tcp_phase_gen u_phase (
    .aclk(aclk),
    .aresetn(aresetn),
    .cycle_end(cycle_end),
    .sample_en(sample_en)
  );

  tcp_prescaler #(
    .WIDTH(8)
  ) u_pre (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(pre_tap),
    .clear(pre_clear),
    .ratio(cfg.ratio),
    .tap(pre_out)
  );

  // Write decode: address and data both held, response channel free
  assign wr_go = aw_held_q && w_held_q && !bvalid_q;
  assign wr_count = wr_go && wstrb_q[0] &&
    (awaddr_q[7:0] == tcp_pkg::TCP_COUNT_OFFSET[7:0]) &&
    (awaddr_q[31:8] == 24'h000000);
  assign wr_option = wr_go && wstrb_q[0] &&
    (awaddr_q[7:0] == tcp_pkg::TCP_OPTION_OFFSET[7:0]) &&
    (awaddr_q[31:8] == 24'h000000);
  assign wr_cmd = wr_go && wstrb_q[0] &&
    (awaddr_q[7:0] == tcp_pkg::TCP_CMD_OFFSET[7:0]) &&
    (awaddr_q[31:8] == 24'h000000) &&
    wdata_q[tcp_pkg::TCP_CMD_WDT_BIT];

  // Selected edge on the count pin, seen in the same clock the pin moves
  assign pin_edge = cfg.edge_fall ? (pin_q && !external_count_input)
                                  : (!pin_q && external_count_input);
  // Prescaler is clocked by the pin only while it belongs to the timer
  assign pre_tap = !cfg.to_wdt && cfg.src_ext ? pin_edge
                 : (!cfg.to_wdt && cycle_end);
  // Clear on count write (timer owned) or watchdog clear (watchdog owned)
  assign pre_clear = (wr_count && !cfg.to_wdt) ||
                     (wr_cmd && cfg.to_wdt);
  // Without prescaler the registered pin, inverted for falling edges, stands in for the prescaler output
  assign inc_src = cfg.to_wdt ? (cfg.edge_fall ? !pin_q : pin_q)
                              : pre_out;

  // Count source, synchroniser and counter
  always_comb
  begin
    pin_d = external_count_input;
    sync_d = sync_q;
    sync_prev_d = sync_prev_q;
    inhibit_d = inhibit_q;
    count_d = count_q;
    if (sample_en)
    begin
      sync_d = inc_src;
      sync_prev_d = sync_q;
    end
    if (wr_count)
    begin
      count_d = wdata_q[7:0];
      inhibit_d = 2'(tcp_pkg::TCP_INHIBIT_CYCLES);
    end
    else if (cycle_end && inhibit_q != 2'h0)
    begin
      inhibit_d = inhibit_q - 2'h1;
    end
    else if (inhibit_q == 2'h0)
    begin
      if (!cfg.src_ext && cycle_end &&
          (cfg.to_wdt || (sync_q && !sync_prev_q)))
        count_d = count_q + 8'h01;
      else if (cfg.src_ext && sample_en && sync_q && !sync_prev_q)
        count_d = count_q + 8'h01;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_q <= 1'b0;
      // Reset option picks falling edges, so an idle-low pin reads high;
      // starting the detector high avoids a false count after reset
      sync_q <= 1'b1;
      sync_prev_q <= 1'b1;
      inhibit_q <= 2'h0;
      count_q <= tcp_pkg::TCP_COUNT_RESET;
    end
    else
    begin
      pin_q <= pin_d;
      sync_q <= sync_d;
      sync_prev_q <= sync_prev_d;
      inhibit_q <= inhibit_d;
      count_q <= count_d;
    end
  end

  // Option register and registered side outputs
  always_comb
  begin
    option_d = option_q;
    if (wr_option)
      option_d = wdata_q[7:0];
    // Counter mode overrides direction so the pin is always an input
    dir_d = option_q[tcp_pkg::TCP_SRC_BIT] || pin_direction_control;
    assign_d = option_q[tcp_pkg::TCP_ASSIGN_BIT];
    wclr_d = wr_cmd;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      option_q <= tcp_pkg::TCP_OPTION_RESET;
      dir_q <= 1'b1;
      assign_q <= 1'b1;
      wclr_q <= 1'b0;
    end
    else
    begin
      option_q <= option_d;
      dir_q <= dir_d;
      assign_q <= assign_d;
      wclr_q <= wclr_d;
    end
  end

  // AXI4-Lite write path; address and data accepted in either order
  always_comb
  begin
    aw_held_d = aw_held_q;
    w_held_d = w_held_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    if (s_axi_awvalid && !aw_held_q)
    begin
      aw_held_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held_q)
    begin
      w_held_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (wr_go)
    begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = (wr_count || wr_option ||
        (awaddr_q == tcp_pkg::TCP_CMD_OFFSET)) ?
        tcp_pkg::TCP_RESP_OKAY : tcp_pkg::TCP_RESP_SLVERR;
    end
    else if (bvalid_q && s_axi_bready)
      bvalid_d = 1'b0;
    // Readies registered so the ports come straight from flops
    awready_d = !aw_held_d;
    wready_d = !w_held_d;
  end

  // AXI4-Lite read path; option register is write-only and reads zero
  always_comb
  begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (s_axi_arvalid && !rvalid_q)
    begin
      rvalid_d = 1'b1;
      rdata_d = 32'h0000_0000;
      rresp_d = tcp_pkg::TCP_RESP_OKAY;
      if (s_axi_araddr == tcp_pkg::TCP_COUNT_OFFSET)
        rdata_d = {24'h000000, count_q};
      else if (s_axi_araddr != tcp_pkg::TCP_OPTION_OFFSET &&
               s_axi_araddr != tcp_pkg::TCP_CMD_OFFSET)
        rresp_d = tcp_pkg::TCP_RESP_SLVERR;
    end
    else if (rvalid_q && s_axi_rready)
      rvalid_d = 1'b0;
    arready_d = !rvalid_d;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 32'h0000_0000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= 2'h0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      arready_q <= 1'b1;
    end
    else
    begin
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      arready_q <= arready_d;
    end
  end

  // Ready only while the holding slot is empty
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign count_pin_input_mode = dir_q;
  assign prescaler_to_watchdog = assign_q;
  assign watchdog_clear_instruction = wclr_q;
endmodule // tcp_timer

// *** tcp_pkg.sv ***
// Package of constants and carrier types for the prescaled timer/counter
// Notes on behaviour
// - Source select clear: count every instruction cycle
// - Count write suppresses counting two cycles
// - Source select set: count external pin edges
// - Edge select: clear rising, set falling
// - Prescaler serves timer or watchdog, never both
// - Prescaler counter has no software access
// - Timer prescale ratios 1:2 to 1:256
// - Count is 8-bit read/write register
// - External path sampled on phases two, four
// - No prescaler: pin feeds synchroniser directly
// - Prescaler is ripple divider of external input; code uses a binary counter ticked by pin edges or instruction cycles
// - Count changes only after synchronisation; internal count without prescaler bypasses the synchroniser
// - Counter mode forces pin to input
// - Count write clears timer-assigned prescaler
// - Watchdog clear clears watchdog-assigned prescaler
// - Reset loads prescaler with zeros
// - Option bits 3:0 hold assignment, ratio
package tcp_pkg;
  // Count register sits at word index 1; the bus sees four bytes per word
  localparam int TCP_COUNT_INDEX = 1;
  localparam logic [31:0] TCP_COUNT_OFFSET = 32'(4 * TCP_COUNT_INDEX);
  localparam logic [31:0] TCP_OPTION_OFFSET = 32'h0000_0008;
  localparam logic [31:0] TCP_CMD_OFFSET = 32'h0000_000C;
  localparam logic [7:0] TCP_OPTION_RESET = 8'hFF;
  localparam logic [7:0] TCP_COUNT_RESET = 8'h00;
  localparam logic [7:0] TCP_PRESCALE_RESET = 8'h00;
  localparam int TCP_SRC_BIT = 5;
  localparam int TCP_EDGE_BIT = 4;
  localparam int TCP_ASSIGN_BIT = 3;
  localparam int TCP_RATIO_MSB = 2;
  localparam int TCP_CMD_WDT_BIT = 0;
  localparam int TCP_INHIBIT_CYCLES = 2;
  localparam int TCP_PHASES = 4;
  localparam logic [1:0] TCP_RESP_OKAY = 2'b00;
  localparam logic [1:0] TCP_RESP_SLVERR = 2'b10;

  // Decoded option fields handed to the counting core
  typedef struct packed {
    logic src_ext;
    logic edge_fall;
    logic to_wdt;
    logic [2:0] ratio;
  } tcp_cfg_type;
endpackage

// *** tcp_phase_gen.sv ***
`timescale 1ns/1ns
// Instruction-cycle phase generator, four clocks per instruction cycle
module tcp_phase_gen (
  input wire logic aclk,
  input wire logic aresetn,
  output logic cycle_end,
  output logic sample_en
);
  logic [1:0] phase_q;
  logic [1:0] phase_d;

  // Free-running phase counter
  always_comb
  begin
    phase_d = phase_q + 2'h1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      phase_q <= 2'h0;
    else
      phase_q <= phase_d;
  end

  // Sampling on the second and fourth phase of each cycle
  assign sample_en = phase_q[0];
  assign cycle_end = (phase_q == 2'h3);
endmodule // tcp_phase_gen

// *** tcp_prescaler.sv ***
`timescale 1ns/1ns
// Shared 8-bit prescaler and selected-tap output
module tcp_prescaler #(
  parameter int WIDTH = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick,
  input wire logic clear,
  input wire logic [2:0] ratio,
  output logic tap
);
  logic [WIDTH-1:0] cnt_q; // No bus path reads or loads this
  logic [WIDTH-1:0] cnt_d;

  // Taps and ratio field assume exactly eight stages
  if (WIDTH != 8)
  begin : g_width_check
    $error("tcp_prescaler: WIDTH must be 8");
  end

  // Divider; a binary counter gives the same symmetric taps as a ripple
  // chain without asynchronous clocks
  always_comb
  begin
    cnt_d = cnt_q;
    if (clear)
      cnt_d = tcp_pkg::TCP_PRESCALE_RESET;
    else if (tick)
      cnt_d = cnt_q + 8'h01;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cnt_q <= tcp_pkg::TCP_PRESCALE_RESET;
    else
      cnt_q <= cnt_d;
  end

  // Bit n toggles at 1:2^(n+1), so 000 gives 1:2 and 111 gives 1:256
  assign tap = cnt_q[ratio];
endmodule // tcp_prescaler

// *** tcp_props.sv ***
// Port checker for the prescaled timer/counter
`timescale 1ns/1ns
module tcp_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pin_direction_control,
  input wire logic count_pin_input_mode,
  input wire logic prescaler_to_watchdog,
  input wire logic watchdog_clear_instruction
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Write answer two edges after both halves are taken together
  AST_WRESP: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  AST_RRESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  AST_RWIDTH: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  AST_PINDIR: assert property (
    pin_direction_control |=> count_pin_input_mode)
    else $error("pin not input");
  AST_WDTPULSE: assert property (
    watchdog_clear_instruction |=> !watchdog_clear_instruction)
    else $error("clear pulse too long");
  AST_RSTVAL: assert property (
    $rose(aresetn) |-> prescaler_to_watchdog && count_pin_input_mode)
    else $error("reset option state wrong");
  // Main traffic seen at least once
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property (watchdog_clear_instruction);
endmodule // tcp_props

bind tcp_timer tcp_props u_props (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .pin_direction_control,
  .count_pin_input_mode, .prescaler_to_watchdog,
  .watchdog_clear_instruction);

// *** tcp_pulse_src.sv ***
// Behavioural pulse source that drives the external count pin
`timescale 1ns/1ns
module tcp_pulse_src (
  input wire logic aclk,
  input wire logic start,
  input wire logic [15:0] toggles,
  input wire logic [3:0] half,
  output logic pin,
  output logic busy
);
  int n;
  initial
  begin
    pin = 1'b0;
    busy = 1'b0;
  end
  // Toggle the pin on request; the pin holds its level when idle
  always @(posedge aclk)
  begin
    if (start && !busy)
    begin
      busy <= 1'b1;
      for (n = 0; n < toggles; n++)
      begin
        repeat ((half < 4'h2) ? 4'h2 : half) @(posedge aclk);
        pin <= ~pin;
      end
      @(posedge aclk);
      busy <= 1'b0;
    end
  end
endmodule // tcp_pulse_src

// *** test_tcp_timer.sv ***
// Self-checking bench for the prescaled timer/counter
`timescale 1ns/1ns
`define CHK(nm, e, a) begin total_checks++; if ((a) !== (e)) begin \
  error_cnt++; $display("BAD %s exp %0h got %0h", nm, e, a); end end
module test_tcp_timer;
  logic aclk = 1'b0, aresetn = 1'b0, start = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF, half = 4'h2;
  logic [15:0] toggles = '0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic pin_direction_control = 1'b0, external_count_input, busy;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, count_pin_input_mode, prescaler_to_watchdog;
  logic watchdog_clear_instruction;
  logic [34:0] note_q[$];
  logic [34:0] nt;
  int error_cnt = 0, total_checks = 0, clr_cnt = 0;
  localparam logic [1:0] OK = tcp_pkg::TCP_RESP_OKAY;
  localparam logic [1:0] ERR = tcp_pkg::TCP_RESP_SLVERR;
  localparam logic [31:0] CNT = tcp_pkg::TCP_COUNT_OFFSET;
  localparam logic [31:0] OPT = tcp_pkg::TCP_OPTION_OFFSET;
  tcp_timer dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .external_count_input,
    .pin_direction_control, .count_pin_input_mode,
    .prescaler_to_watchdog, .watchdog_clear_instruction);
  tcp_pulse_src src (.aclk, .start, .toggles, .half,
    .pin(external_count_input), .busy);
  // 100 MHz clock
  always #5 aclk = ~aclk;
  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic hang;
    error_cnt++;
    close_out();
  endtask
  // Write one byte; valids drop as each channel is taken
  task automatic wr(input logic [31:0] a, input logic [7:0] d,
    input logic [1:0] r);
    int t;
    logic pend;
    // Let an edge pass so the previous release is not overwritten
    @(posedge aclk);
    note_q.push_back({1'b0, r, 32'h0});
    pend = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (t = 0; t < 50 && pend; t++)
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        s_axi_bready <= 1'b0;
        pend = 1'b0;
      end
    end
    if (pend) hang();
  endtask
  // Read one word; the note may ask to ignore the data
  task automatic rd(input logic [31:0] a, input logic [34:0] n,
    output logic [31:0] d);
    int t;
    logic pend;
    @(posedge aclk);
    note_q.push_back(n);
    pend = 1'b1;
    d = 32'h0000_0000;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (t = 0; t < 50 && pend; t++)
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
        pend = 1'b0;
      end
    end
    if (pend) hang();
  endtask
  // Ask the source for n pin toggles at a random pace
  task automatic pulse(input int n);
    int t;
    repeat (12) @(posedge aclk);
    toggles <= n[15:0];
    half <= 4'($urandom_range(2, 4));
    start <= 1'b1;
    for (t = 0; t < 20000 && !busy; t++) @(posedge aclk);
    if (!busy) hang();
    start <= 1'b0;
    for (t = 0; t < 20000 && busy; t++) @(posedge aclk);
    if (t == 20000) hang();
    repeat (12) @(posedge aclk);
  endtask
  // Pair each bus answer with the oldest note
  always @(posedge aclk)
  begin
    if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready))
    begin
      nt = note_q.pop_front();
      if (s_axi_bvalid)
        `CHK("bresp", nt[33:32], s_axi_bresp)
      else
      begin
        `CHK("rresp", nt[33:32], s_axi_rresp)
        if (!nt[34]) `CHK("rdata", nt[31:0], s_axi_rdata)
      end
    end
    if (watchdog_clear_instruction === 1'b1) clr_cnt++;
  end
  // Main sequence
  initial
  begin
    logic [31:0] d;
    int r;
    d = $urandom(21);
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK("p2w", 1'b1, prescaler_to_watchdog)
    `CHK("inmode", 1'b1, count_pin_input_mode)
    rd(CNT, {1'b0, OK, 32'h0}, d);
    rd(OPT, {1'b0, OK, 32'h0}, d);
    rd(32'h10, {1'b0, ERR, 32'h0}, d);
    wr(32'h10, 8'h5A, ERR);
    $display("reset test done");
    wr(OPT, 8'h38, OK);
    wr(CNT, 8'h00, OK);
    pulse(3);
    rd(CNT, {1'b0, OK, 32'h1}, d);
    wr(OPT, 8'h28, OK);
    wr(CNT, 8'h00, OK);
    pulse(3);
    rd(CNT, {1'b0, OK, 32'h1}, d);
    $display("edge test done");
    for (r = 0; r < 8; r++)
    begin
      wr(OPT, 8'h20 | r[7:0], OK);
      wr(CNT, 8'h00, OK);
      pulse(4 << r);
      rd(CNT, {1'b0, OK, 32'h1}, d);
      `CHK("p2w", 1'b0, prescaler_to_watchdog)
    end
    $display("prescale test done");
    wr(OPT, 8'h08, OK);
    for (r = 0; r < 4; r++)
    begin
      pin_direction_control <= 1'($urandom_range(0, 1));
      repeat (3) @(posedge aclk);
      `CHK("inmode", pin_direction_control, count_pin_input_mode)
    end
    `CHK("p2w", 1'b1, prescaler_to_watchdog)
    wr(CNT, 8'hFE, OK);
    rd(CNT, {1'b0, OK, 32'hFE}, d);
    repeat (28) @(posedge aclk);
    rd(CNT, {1'b1, OK, 32'h0}, d);
    `CHK("wrap", 1'b1, (d[7:0] >= 8'h03 && d[7:0] <= 8'h06))
    $display("timer test done");
    // Timer mode with the prescaler at 1:2
    wr(OPT, 8'h00, OK);
    wr(CNT, 8'h00, OK);
    repeat (60) @(posedge aclk);
    rd(CNT, {1'b1, OK, 32'h0}, d);
    `CHK("ptimer", 1'b1, (d[7:0] >= 8'h05 && d[7:0] <= 8'h08))
    $display("prescaled timer test done");
    clr_cnt = 0;
    wr(tcp_pkg::TCP_CMD_OFFSET, 8'h00, OK);
    wr(tcp_pkg::TCP_CMD_OFFSET, 8'h01, OK);
    repeat (4) @(posedge aclk);
    `CHK("wclr", 1, clr_cnt)
    $display("clear test done");
    close_out();
  end
endmodule // test_tcp_timer
